// *** logic/cbr_regs.svh ***
/*
 * Constants for the bit, port and return execution block: register
 * offsets, field positions, reset values, opcodes and timing counts.
 * Assumes it is included once per compile unit; guarded anyway.
 */
`ifndef CBR_REGS_SVH
`define CBR_REGS_SVH

// register byte offsets on apb
`define CBR_OFF_CTRL      12'h000
`define CBR_OFF_INSN      12'h004
`define CBR_OFF_ACC       12'h008
`define CBR_OFF_FLAGS     12'h00C
`define CBR_OFF_PORTS     12'h010
`define CBR_OFF_PC        12'h014
`define CBR_OFF_SP        12'h018
`define CBR_OFF_MEM       12'h01C
`define CBR_OFF_STACK     12'h020
`define CBR_OFF_SAVE      12'h024
`define CBR_OFF_STATUS    12'h028

// opcodes, 10-bit words
`define CBR_OP_ROTR       10'h01D
`define CBR_OP_BCLR_BASE  10'h04C
`define CBR_OP_CCLR       10'h006
`define CBR_OP_PCCLR      10'h28C
`define CBR_OP_PDCLR      10'h014
`define CBR_OP_RET        10'h044
`define CBR_OP_IRET       10'h046
`define CBR_OP_RETSK      10'h045

// field positions
`define CBR_CTRL_GO_BIT   0
`define CBR_CTRL_INTK_BIT 1

// reset values
`define CBR_RST_PORTD     8'hFF
`define CBR_RST_PORTC     1'b1

// cycle counts
`define CBR_CYC_RETURN    2'h2
`define CBR_CYC_SINGLE    2'h1

`endif

// *** logic/cbr_pkg.sv ***
/*
 * Types used by the execution block; its stack helper imports none of them.
 * Assumes the header of constants is compiled alongside.
 */
package cbr_pkg;

    // execution state, gray along idle -> exec -> return second cycle
    typedef enum logic [1:0] {
        CBR_IDLE = 2'b00,
        CBR_EXEC = 2'b01,
        CBR_RET2 = 2'b11
    } cbr_state_t;

    // state saved on interrupt entry and restored on interrupt return
    typedef struct packed {
        logic [2:0] x;
        logic [3:0] y;
        logic [1:0] z;
        logic       skip;
        logic       nop_mode;
        logic [3:0] a;
        logic [3:0] b;
    } cbr_save_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cbr_apb_req_t;

endpackage

// *** logic/cbr_stack.sv ***
/*
 * Return stack for the execution block: an array of program counters,
 * a push port and a combinational read of the entry at the pointer.
 * Assumes the owner keeps the pointer in range.
 */
`timescale 1ns/1ps

module cbr_stack #(
    parameter int DEPTH = 8,
    parameter int PCW   = 13,
    parameter int SPW   = 3
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           push_i,
    input  wire logic [SPW-1:0] push_idx_i,
    input  wire logic [PCW-1:0] push_pc_i,
    input  wire logic [SPW-1:0] rd_idx_i,
    output logic      [PCW-1:0] rd_pc_o
);

    logic [PCW-1:0] mem_q [DEPTH];
    logic [PCW-1:0] mem_d [DEPTH];

    // next contents: only the pushed entry changes
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (push_i) begin
            mem_d[push_idx_i] = push_pc_i;
        end
    end

    // register the entries; reset clears them so reads are defined
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst_i) begin
                mem_q[i] <= '0;
            end else begin
                mem_q[i] <= mem_d[i];
            end
        end
    end

    assign rd_pc_o = mem_q[rd_idx_i];

endmodule // cbr_stack

// *** logic/cbr_exec.sv ***
/*
 * Execution logic for the bit, port and return instructions of a 4-bit
 * core, with an apb register file through which software loads the
 * core state, writes an instruction word and starts it.
 * Assumes one 10 MHz clock and a synchronous active-high reset; the
 * apb master holds each request until pready.
 */
`timescale 1ns/1ps
`include "cbr_regs.svh"

// What this block does
// - rotate accumulator right through carry, one cycle
// - clear memory bit j at data pointer
// - interrupt return pops pc, decrements pointer
// - interrupt return restores pointer, skip, mode, A, B
// - return-and-skip pops pc over two cycles
// - return-and-skip skips the following instruction
module cbr_exec
    import cbr_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int PCW   = 13,
    parameter int SPW   = 3
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    output logic      [7:0]  PORTD_O,
    output logic             PORTC_O,
    output logic             BUSY_O
);

    ////////////////////////////////////////////////////////////////////
    // state

    cbr_state_t     state_q, state_d;
    logic [9:0]     insn_q, insn_d;
    logic [3:0]     acc_q, acc_d;
    logic [3:0]     accb_q, accb_d;
    logic           carry_flag_q, carry_flag_d;
    logic           skip_q, skip_d;
    logic           nop_mode_q, nop_mode_d;
    logic [2:0]     dp_x_q, dp_x_d;
    logic [3:0]     dp_y_q, dp_y_d;
    logic [1:0]     dp_z_q, dp_z_d;
    logic [3:0]     mem_q, mem_d;
    logic [7:0]     portd_q, portd_d;
    logic           portc_q, portc_d;
    logic [PCW-1:0] pc_q, pc_d;
    logic [SPW-1:0] sp_q, sp_d;
    cbr_save_t      save_q, save_d;
    logic [31:0]    prdata_q, prdata_d;
    logic           pready_q, pready_d;
    logic           pslverr_q, pslverr_d;
    logic [3:0]     done_cnt_q, done_cnt_d;
    logic           busy_q, busy_d;

    logic           push;
    logic [PCW-1:0] stack_pc;
    cbr_apb_req_t   req;
    logic           acc_wr;

    // the nibble addressed by the data pointer is modelled as one word
    function automatic logic [3:0] clear_bit(input logic [3:0] v,
                                             input logic [1:0] j);
        logic [3:0] r;
        r    = v;
        r[j] = 1'b0;
        return r;
    endfunction

    assign req    = '{write: PWRITE_I, addr: PADDR_I, wdata: PWDATA_I};
    // write takes effect in the access cycle, answered the same edge
    assign acc_wr = PSEL_I && PENABLE_I && !pready_q && req.write;
    assign push   = acc_wr && req.addr == `CBR_OFF_STACK;
    // busy is registered from the next state so the pin is a flop
    assign busy_d = state_d != CBR_IDLE;

    cbr_stack #(
        .DEPTH (DEPTH),
        .PCW   (PCW),
        .SPW   (SPW)
    ) u_stack (
        .clk_i      (SYS_CLK_I),
        .rst_i      (SYS_RST_I),
        .push_i     (push),
        .push_idx_i (sp_q),
        .push_pc_i  (req.wdata[PCW-1:0]),
        .rd_idx_i   (sp_q),
        .rd_pc_o    (stack_pc)
    );

    ////////////////////////////////////////////////////////////////////
    // next state: bus writes, then instruction execution

    always_comb begin
        state_d      = state_q;
        insn_d       = insn_q;
        acc_d        = acc_q;
        accb_d       = accb_q;
        carry_flag_d = carry_flag_q;
        skip_d       = skip_q;
        nop_mode_d   = nop_mode_q;
        dp_x_d       = dp_x_q;
        dp_y_d       = dp_y_q;
        dp_z_d       = dp_z_q;
        mem_d        = mem_q;
        portd_d      = portd_q;
        portc_d      = portc_q;
        pc_d         = pc_q;
        sp_d         = sp_q;
        save_d       = save_q;
        done_cnt_d   = done_cnt_q;

        // software writes other than stack pushes are ignored while an instruction runs
        if (acc_wr && state_q == CBR_IDLE) begin
            case (req.addr)
                `CBR_OFF_CTRL: begin
                    if (req.wdata[`CBR_CTRL_GO_BIT]) begin
                        state_d = CBR_EXEC;
                    end
                end
                `CBR_OFF_INSN:  insn_d = req.wdata[9:0];
                `CBR_OFF_ACC: begin
                    acc_d  = req.wdata[3:0];
                    accb_d = req.wdata[7:4];
                end
                `CBR_OFF_FLAGS: begin
                    carry_flag_d = req.wdata[0];
                    skip_d       = req.wdata[1];
                    nop_mode_d   = req.wdata[2];
                    dp_x_d       = req.wdata[6:4];
                    dp_y_d       = req.wdata[11:8];
                    dp_z_d       = req.wdata[13:12];
                end
                `CBR_OFF_PORTS: begin
                    portd_d = req.wdata[7:0];
                    portc_d = req.wdata[8];
                end
                `CBR_OFF_PC:   pc_d   = req.wdata[PCW-1:0];
                `CBR_OFF_SP:   sp_d   = req.wdata[SPW-1:0];
                `CBR_OFF_MEM:  mem_d  = req.wdata[3:0];
                `CBR_OFF_SAVE: save_d = req.wdata[$bits(cbr_save_t)-1:0];
                default: ;
            endcase
        end

        case (state_q)
            CBR_IDLE: ;
            CBR_EXEC: begin
                state_d = CBR_IDLE;
                pc_d    = pc_q + PCW'(1);
                done_cnt_d = done_cnt_q + 4'h1;
                if (insn_q == `CBR_OP_ROTR) begin
                    acc_d        = {carry_flag_q, acc_q[3:1]};
                    carry_flag_d = acc_q[0];
                end else if (insn_q[9:2] == 8'(`CBR_OP_BCLR_BASE >> 2))
                begin
                    mem_d = clear_bit(mem_q, insn_q[1:0]);
                end else if (insn_q == `CBR_OP_CCLR) begin
                    carry_flag_d = 1'b0;
                end else if (insn_q == `CBR_OP_PCCLR) begin
                    portc_d = 1'b0;
                end else if (insn_q == `CBR_OP_PDCLR) begin
                    // y above 7 selects no pin
                    if (!dp_y_q[3]) begin
                        portd_d[dp_y_q[2:0]] = 1'b0;
                    end
                end else if (insn_q == `CBR_OP_IRET) begin
                    pc_d       = stack_pc;
                    sp_d       = sp_q - SPW'(1);
                    dp_x_d     = save_q.x;
                    dp_y_d     = save_q.y;
                    dp_z_d     = save_q.z;
                    skip_d     = save_q.skip;
                    nop_mode_d = save_q.nop_mode;
                    acc_d      = save_q.a;
                    accb_d     = save_q.b;
                end else if (insn_q == `CBR_OP_RET ||
                             insn_q == `CBR_OP_RETSK) begin
                    // returns pop now and finish in a second cycle
                    pc_d       = stack_pc;
                    sp_d       = sp_q - SPW'(1);
                    state_d    = CBR_RET2;
                    done_cnt_d = done_cnt_q;
                end
            end
            CBR_RET2: begin
                state_d    = CBR_IDLE;
                done_cnt_d = done_cnt_q + 4'h1;
                // skipped word is stepped over, never executed
                if (insn_q == `CBR_OP_RETSK) begin
                    pc_d = pc_q + PCW'(1);
                end
            end
            default: state_d = CBR_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // apb answer: one wait state, read data from current state

    always_comb begin
        pready_d  = PSEL_I && PENABLE_I && !pready_q;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;
        if (PSEL_I && PENABLE_I && !pready_q) begin
            prdata_d = 32'h0000_0000;
            case (req.addr)
                `CBR_OFF_CTRL:  prdata_d = 32'h0000_0000;
                `CBR_OFF_INSN:  prdata_d[9:0] = insn_q;
                `CBR_OFF_ACC:   prdata_d[7:0] = {accb_q, acc_q};
                `CBR_OFF_FLAGS: prdata_d[13:0] = {dp_z_q, dp_y_q, 1'b0,
                    dp_x_q, 1'b0, nop_mode_q, skip_q, carry_flag_q};
                `CBR_OFF_PORTS: prdata_d[8:0] = {portc_q, portd_q};
                `CBR_OFF_PC:    prdata_d[PCW-1:0] = pc_q;
                `CBR_OFF_SP:    prdata_d[SPW-1:0] = sp_q;
                `CBR_OFF_MEM:   prdata_d[3:0] = mem_q;
                `CBR_OFF_STACK: prdata_d[PCW-1:0] = stack_pc;
                `CBR_OFF_SAVE:
                    prdata_d[$bits(cbr_save_t)-1:0] = save_q;
                `CBR_OFF_STATUS: prdata_d[5:0] = {done_cnt_q,
                    state_q};
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state_q      <= CBR_IDLE;
            insn_q       <= 10'h000;
            acc_q        <= 4'h0;
            accb_q       <= 4'h0;
            carry_flag_q <= 1'b0;
            skip_q       <= 1'b0;
            nop_mode_q   <= 1'b0;
            dp_x_q       <= 3'h0;
            dp_y_q       <= 4'h0;
            dp_z_q       <= 2'h0;
            mem_q        <= 4'h0;
            portd_q      <= `CBR_RST_PORTD;
            portc_q      <= `CBR_RST_PORTC;
            pc_q         <= '0;
            sp_q         <= '0;
            save_q       <= '0;
            prdata_q     <= 32'h0000_0000;
            pready_q     <= 1'b0;
            pslverr_q    <= 1'b0;
            done_cnt_q   <= 4'h0;
            busy_q       <= 1'b0;
        end else begin
            state_q      <= state_d;
            insn_q       <= insn_d;
            acc_q        <= acc_d;
            accb_q       <= accb_d;
            carry_flag_q <= carry_flag_d;
            skip_q       <= skip_d;
            nop_mode_q   <= nop_mode_d;
            dp_x_q       <= dp_x_d;
            dp_y_q       <= dp_y_d;
            dp_z_q       <= dp_z_d;
            mem_q        <= mem_d;
            portd_q      <= portd_d;
            portc_q      <= portc_d;
            pc_q         <= pc_d;
            sp_q         <= sp_d;
            save_q       <= save_d;
            prdata_q     <= prdata_d;
            pready_q     <= pready_d;
            pslverr_q    <= pslverr_d;
            done_cnt_q   <= done_cnt_d;
            busy_q       <= busy_d;
        end
    end

    assign PRDATA_O  = prdata_q;
    assign PREADY_O  = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign PORTD_O   = portd_q;
    assign PORTC_O   = portc_q;
    assign BUSY_O    = busy_q;

endmodule // cbr_exec

// *** tb/cbr_exec_asserts.sv ***
/* port checker for the bit, port and return execution block.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module cbr_exec_asserts (
    input wire logic        SYS_CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic [7:0]  PORTD_O,
    input wire logic        PORTC_O,
    input wire logic        BUSY_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // register writes move the ports too, so they are kept apart
    logic wr_acc;
    assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
    chk_ready_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O
        |=> PREADY_O) else $error("ready not after one wait");
    chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready held");
    chk_ready_cause: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I))
        else $error("ready without access");
    chk_err_ready: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    chk_err_zero: assert property (PSLVERR_O |-> PRDATA_O == 32'h0)
        else $error("error read not zero");
    chk_portc_cause: assert property ($fell(PORTC_O) &&
        !$past(wr_acc) |-> $past(BUSY_O)) else $error("port c fell idle");
    chk_portd_one: assert property ((PORTD_O != $past(PORTD_O)) &&
        !$past(wr_acc) |-> $past(BUSY_O) &&
        $countones($past(PORTD_O) & ~PORTD_O) == 1 &&
        (PORTD_O & ~$past(PORTD_O)) == 8'h00) else $error("port d change");
    chk_busy_bound: assert property (BUSY_O ##1 BUSY_O |=> !BUSY_O)
        else $error("busy over two cycles");
endmodule // cbr_exec_asserts
////////////////////////////////////////
bind cbr_exec cbr_exec_asserts u_chk (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .PORTD_O(PORTD_O), .PORTC_O(PORTC_O),
    .BUSY_O(BUSY_O));

// *** tb/cbr_prog_rom.sv ***
/* program memory model: fixed 10-bit instruction words by index.
   assumes the bench loads each fetched word into the block. */
`timescale 1ns/1ps
module cbr_prog_rom (
    input  wire logic [3:0] addr_i,
    output logic      [9:0] word_o
);
    // empty slots read all ones so a stray fetch is never a clean op
    always_comb begin
        case (addr_i)
            4'h0: word_o = 10'h01D;
            4'h1: word_o = 10'h006;
            4'h2: word_o = 10'h28C;
            4'h3: word_o = 10'h014;
            4'h4: word_o = 10'h044;
            4'h5: word_o = 10'h045;
            4'h6: word_o = 10'h046;
            4'h8, 4'h9, 4'hA, 4'hB: word_o = 10'h04C + {8'h00, addr_i[1:0]};
            default: word_o = 10'h3FF;
        endcase
    end
endmodule // cbr_prog_rom

// *** tb/cbr_exec_tb.sv ***
/* self-checking bench for the execution block, over apb.
   assumes the checker is bound and the program model is compiled. */
`timescale 1ns/1ps
`include "cbr_regs.svh"
module cbr_exec_tb;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, portc, busy;
    logic [7:0] portd;
    logic [3:0] rom_addr = 4'h0;
    logic [9:0] rom_word;
    int err_total = 0, n_tests = 0, busy_n = 0;
    localparam logic [11:0] OFF_SPTR = 12'h018, OFF_NONE = 12'h02C;
    localparam logic [3:0] W_ROT = 4'h0, W_CCLR = 4'h1, W_PCCLR = 4'h2,
        W_PDCLR = 4'h3, W_RET = 4'h4, W_RETSK = 4'h5, W_IRET = 4'h6,
        W_BCLR = 4'h8;
    cbr_exec u_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .PORTD_O(portd), .PORTC_O(portc), .BUSY_O(busy));
    cbr_prog_rom u_rom (.addr_i(rom_addr), .word_o(rom_word));
    // clock and a count of busy cycles seen at rising edges
    always #50 clk = ~clk;
    always @(posedge clk) if (busy === 1'b1) busy_n <= busy_n + 1;
    ////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        // ready is read at the edge, before that edge updates it
        while (pready !== 1'b1) begin
            if (n++ > 20) begin
                err_total++;
                $display("BAD %0t no ready", $time);
                complete_run();
            end
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r; logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] x, string s);
        logic [31:0] r; logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, x, s);
    endtask
    // fetch a word, start it, then judge how long busy stood
    task automatic run(input logic [3:0] idx, input int cyc);
        rom_addr <= idx;
        @(posedge clk);
        busy_n = 0;
        wr(`CBR_OFF_INSN, {22'h0, rom_word});
        wr(`CBR_OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        check(32'(busy_n), 32'(cyc), "cycles");
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r; logic e;
        rc(`CBR_OFF_PORTS, 32'h1FF, "ports reset");
        rc(`CBR_OFF_FLAGS, 32'h0, "flags reset");
        apb(1'b0, OFF_NONE, 32'h0, r, e);
        check({31'h0, e}, 32'h1, "unmapped err");
        check(r, 32'h0, "unmapped data");
        $display("reset test done");
    endtask
    task automatic t_rotate();
        wr(`CBR_OFF_ACC, 32'h06);
        wr(`CBR_OFF_FLAGS, 32'h1);
        run(W_ROT, 1);
        rc(`CBR_OFF_ACC, 32'h0B, "rot acc");
        rc(`CBR_OFF_FLAGS, 32'h0, "rot carry");
        run(W_ROT, 1);
        rc(`CBR_OFF_ACC, 32'h05, "rot acc 2");
        rc(`CBR_OFF_FLAGS, 32'h1, "rot carry 2");
        $display("rotate test done");
    endtask
    task automatic t_bits();
        for (int j = 0; j < 4; j++) begin
            wr(`CBR_OFF_MEM, 32'hF);
            run(4'(W_BCLR + j), 1);
            rc(`CBR_OFF_MEM, 32'hF & ~(32'h1 << j), "bit clear");
        end
        wr(`CBR_OFF_FLAGS, 32'h7);
        run(W_CCLR, 1);
        rc(`CBR_OFF_FLAGS, 32'h6, "carry clear");
        wr(`CBR_OFF_FLAGS, 32'h1);
        run(W_PCCLR, 1);
        rc(`CBR_OFF_PORTS, 32'h0FF, "port c clear");
        check(32'(portc), 32'h0, "port c pin");
        rc(`CBR_OFF_FLAGS, 32'h1, "port c carry");
        $display("bit test done");
    endtask
    task automatic t_portd();
        for (int y = 0; y < 9; y++) begin
            wr(`CBR_OFF_PORTS, 32'h1FF);
            wr(`CBR_OFF_FLAGS, 32'(y) << 8);
            run(W_PDCLR, 1);
            rc(`CBR_OFF_PORTS, y < 8 ? 32'h1FF & ~(32'h1 << y) : 32'h1FF,
                "port d");
            check(32'(portd), y < 8 ? 32'hFF & ~(32'h1 << y) : 32'hFF,
                "port d pin");
        end
        $display("port d test done");
    endtask
    task automatic t_returns();
        wr(OFF_SPTR, 32'h3);
        wr(`CBR_OFF_STACK, 32'hABC);
        run(W_RET, 2);
        rc(`CBR_OFF_PC, 32'hABC, "ret pc");
        rc(OFF_SPTR, 32'h2, "ret ptr");
        wr(`CBR_OFF_STACK, 32'h200);
        run(W_RETSK, 2);
        rc(`CBR_OFF_PC, 32'h201, "skip pc");
        rc(OFF_SPTR, 32'h1, "skip ptr");
        wr(`CBR_OFF_STACK, 32'h345);
        wr(`CBR_OFF_SAVE, 32'h5AAC3);
        wr(`CBR_OFF_FLAGS, 32'h0);
        run(W_IRET, 1);
        rc(`CBR_OFF_PC, 32'h345, "iret pc");
        rc(OFF_SPTR, 32'h0, "iret ptr");
        rc(`CBR_OFF_FLAGS, 32'h2A52, "iret flags");
        rc(`CBR_OFF_ACC, 32'h3C, "iret acc");
        $display("return test done");
    endtask
    ////////////////////////////////////////
    // main sequence, reset held for five cycles
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_rotate();
        t_bits();
        t_portd();
        t_returns();
        complete_run();
    end
endmodule // cbr_exec_tb
